// >>> ksp_params.svh
`ifndef KSP_PARAMS_SVH
`define KSP_PARAMS_SVH
// ****************************************
// word layout
// ****************************************
`define KSP_WORD_W 8
`define KSP_ADDR_MSB 7
`define KSP_ADDR_LSB 6
`define KSP_DATA_W 6
`define KSP_SEL_BIT 5
// ****************************************
// register codes and reset values
// ****************************************
`define KSP_REF_CODE 2'h0
`define KSP_KNK_CODE 2'h1
`define KSP_BAL_CODE 2'h2
`define KSP_EXT_CODE 2'h3
`define KSP_TC_SUB 1'h0
`define KSP_SEL_SUB 1'h1
`define KSP_FREQ_RST 6'h00
`define KSP_BAL_RST 6'h00
`define KSP_TC_RST 5'h00
`define KSP_SEL_RST 5'h00
// synchroniser idle levels: sck 0, cs_n 1, mosi 0, int/hold 0, cmp 0
`define KSP_SYNC_RST 5'h08
// selection register fields: [4:2] test code, [1] sensor, [0] attenuated channel
`define KSP_SEL_TEST_MSB 4
`define KSP_SEL_TEST_LSB 2
`define KSP_SEL_SENS_BIT 1
`define KSP_SEL_ATT_BIT 0
// test codes
`define KSP_TST_OFF 3'h0
`define KSP_TST_REG 3'h1
`define KSP_TST_MOSI 3'h2
`define KSP_TST_CMP 3'h3
`define KSP_TST_FILT 3'h4
`define KSP_TST_GAIN 3'h5
`define KSP_TST_AAF 3'h6
`define KSP_TST_INTG 3'h7
// ****************************************
// timing at 50 MHz
// ****************************************
`define KSP_CLK_NS 20
`define KSP_INT_LAT_US 20
`define KSP_INT_LAT_CYC ((`KSP_INT_LAT_US * 1000) / `KSP_CLK_NS)
// cycles lost to the pin synchroniser and state entry before the arm count runs
`define KSP_ENTRY_LAG 4
`define KSP_HOLD_LAT_US 20
`define KSP_HOLD_LAT_CYC ((`KSP_HOLD_LAT_US * 1000) / `KSP_CLK_NS)
`define KSP_TOGGLE_US 1
`define KSP_TOGGLE_CYC ((`KSP_TOGGLE_US * 1000 + `KSP_CLK_NS - 1) / `KSP_CLK_NS)
`define KSP_CNT_W 16
`endif

// >>> ksp_pkg.sv
package ksp_pkg;
  typedef logic [7:0] ksp_word_t;
  typedef logic [5:0] ksp_data_t;
  // integrator control states, gray along idle-arm-run-release
  typedef enum logic [1:0] {
    KSP_HOLD = 2'b00,
    KSP_ARM = 2'b01,
    KSP_INTEG = 2'b11,
    KSP_REL = 2'b10
  } ksp_int_e;
endpackage

// >>> ksp_word_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries one received word from the shifter to the decoder
interface ksp_word_if;
  logic [7:0] word;
  logic valid;
  modport src (output word, output valid);
  modport dst (input word, input valid);
endinterface
`default_nettype wire

// >>> ksp_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ksp_params.svh"
module ksp_shifter (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic sck_s_in,
  input wire logic cs_n_s_in,
  input wire logic mosi_s_in,
  ksp_word_if.src wrd
);
  import ksp_pkg::*;
  logic sck_d_ff;
  logic [7:0] sh_ff;
  logic [3:0] cnt_ff;
  logic valid_ff;
  logic sck_rise;
  assign sck_rise = sck_s_in & ~sck_d_ff;
  // edge history of the synchronised clock
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= sck_s_in;
    end
  end
  // shift msb first on rising sck, only while selected
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_ff <= 8'h00;
      cnt_ff <= 4'h0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      if (cs_n_s_in) begin
        cnt_ff <= 4'h0; // partial words are dropped
      end else if (sck_rise) begin
        sh_ff <= {sh_ff[6:0], mosi_s_in}; // see R1 see R7
        if (cnt_ff == 4'h7) begin
          cnt_ff <= 4'h0;
          valid_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
  assign wrd.word = sh_ff;
  assign wrd.valid = valid_ff;
endmodule
`default_nettype wire

// >>> ksp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ksp_params.svh"
// Overview of operation
// R1: an eight-bit word is shifted in on sck only while chip select is low.
// R2: each received word is decoded and written into exactly one of five registers.
// R3: the registers are reference frequency, knock frequency, balance, time constant, selection.
// R4: the selection register holds test conditions, sensor choice and attenuated channel.
// R5: in test mode the digital output shows a register bit, inverted mosi, or the comparator.
// R6: the test mux selection follows the selection register, routing integrator or inner signals.
// R7: mosi is sampled on the rising sck edge and the master keeps it stable there.
// R8: the master keeps chip select low for eight rising edges before raising it.
// R9: the master waits at least 8 us after chip select rises before raising int/hold.
// R10: at power-up the controller toggles int/hold for at least 1 us.
// R11: without the power-up toggle the first result and first words are flagged invalid; the code flags only the first word and the first result.
// R12: integration starts within 20 us after int/hold rises.
// R13: hold is entered about 20 us after int/hold falls.
// R14: with the antialias output selected the sensor amplifiers are powered down.
// R15: bits 7:6 address, bits 5:0 data; address 3 uses bit 5 to pick time constant or selection.
module ksp_core (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic int_hold_in,
  input wire logic cmp_in,
  output logic [5:0] ref_freq_out,
  output logic [5:0] knock_freq_out,
  output logic [5:0] balance_out,
  output logic [4:0] time_const_out,
  output logic [2:0] test_sel_out,
  output logic sensor_sel_out,
  output logic atten_ch_out,
  output logic [2:0] amux_sel_out,
  output logic amp_pwrdn_out,
  output logic test_dout_out,
  output logic integrate_out,
  output logic data_valid_out,
  output logic result_valid_out
);
  import ksp_pkg::*;
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic sck_s;
  logic cs_n_s;
  logic mosi_s;
  logic ih_s;
  logic cmp_s;
  // reset to the idle pin levels, so no false edge follows reset
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= `KSP_SYNC_RST;
      sync2_ff <= `KSP_SYNC_RST;
    end else begin
      sync1_ff <= {sck_in, cs_n_in, mosi_in, int_hold_in, cmp_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign sck_s = sync2_ff[4];
  assign cs_n_s = sync2_ff[3];
  assign mosi_s = sync2_ff[2];
  assign ih_s = sync2_ff[1];
  assign cmp_s = sync2_ff[0]; // the comparator is asynchronous to this clock too
  // ****************************************
  // word reception
  // ****************************************
  ksp_word_if wrd ();
  ksp_shifter u_shift (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .sck_s_in(sck_s),
    .cs_n_s_in(cs_n_s),
    .mosi_s_in(mosi_s),
    .wrd(wrd)
  );
  // ****************************************
  // power-up toggle tracking
  // ****************************************
  logic ih_d_ff;
  logic [15:0] tog_cnt_ff;
  logic toggled_ff;
  logic first_word_ff;
  logic first_result_ff;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ih_d_ff <= 1'b0;
    end else begin
      ih_d_ff <= ih_s;
    end
  end
  // a high pulse of at least the toggle time counts as the power-up toggle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_cnt_ff <= 16'h0000;
      toggled_ff <= 1'b0;
    end else begin
      if (!ih_s) begin
        tog_cnt_ff <= 16'h0000;
      end else if (tog_cnt_ff != 16'hffff) begin
        tog_cnt_ff <= tog_cnt_ff + 16'h0001;
      end
      if (ih_d_ff && !ih_s && tog_cnt_ff >= 16'(`KSP_TOGGLE_CYC)) begin
        toggled_ff <= 1'b1; // see R10
      end
    end
  end
  // without the toggle the first word and first result are marked invalid
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      first_word_ff <= 1'b1;
      data_valid_out <= 1'b0;
    end else if (wrd.valid) begin
      first_word_ff <= 1'b0;
      data_valid_out <= toggled_ff | ~first_word_ff; // see R11
    end
  end
  // ****************************************
  // decode into the five registers
  // ****************************************
  logic [1:0] addr;
  logic [5:0] data;
  assign addr = wrd.word[`KSP_ADDR_MSB:`KSP_ADDR_LSB]; // see R15
  assign data = wrd.word[`KSP_DATA_W-1:0];
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_freq_out <= `KSP_FREQ_RST;
      knock_freq_out <= `KSP_FREQ_RST;
      balance_out <= `KSP_BAL_RST;
      time_const_out <= `KSP_TC_RST;
      {test_sel_out, sensor_sel_out, atten_ch_out} <= `KSP_SEL_RST;
    end else if (wrd.valid) begin
      // one target per word, see R2 see R3
      if (addr == `KSP_REF_CODE) begin
        ref_freq_out <= data;
      end else if (addr == `KSP_KNK_CODE) begin
        knock_freq_out <= data;
      end else if (addr == `KSP_BAL_CODE) begin
        balance_out <= data;
      end else if (data[`KSP_SEL_BIT] == `KSP_TC_SUB) begin
        time_const_out <= data[4:0];
      end else begin
        test_sel_out <= data[`KSP_SEL_TEST_MSB:`KSP_SEL_TEST_LSB]; // see R4
        sensor_sel_out <= data[`KSP_SEL_SENS_BIT];
        atten_ch_out <= data[`KSP_SEL_ATT_BIT];
      end
    end
  end
  // ****************************************
  // test multiplexer
  // ****************************************
  logic [2:0] bitp_ff;
  logic sel_bit;
  logic nxt_tdout;
  // walks one bit of the chosen register per received word; register index in sensor/atten
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bitp_ff <= 3'h0;
    end else if (wrd.valid) begin
      bitp_ff <= (bitp_ff == 3'h5) ? 3'h0 : bitp_ff + 3'h1;
    end
  end
  always_comb begin
    sel_bit = 1'b0;
    case ({sensor_sel_out, atten_ch_out})
      2'b00: sel_bit = ref_freq_out[bitp_ff];
      2'b01: sel_bit = knock_freq_out[bitp_ff];
      2'b10: sel_bit = balance_out[bitp_ff];
      default: sel_bit = (bitp_ff == 3'h5) ? 1'b0 : time_const_out[bitp_ff];
    endcase
  end
  always_comb begin
    nxt_tdout = 1'b0;
    case (test_sel_out)
      `KSP_TST_REG: nxt_tdout = sel_bit; // see R5
      `KSP_TST_MOSI: nxt_tdout = ~mosi_s;
      `KSP_TST_CMP: nxt_tdout = cmp_s;
      default: nxt_tdout = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      test_dout_out <= 1'b0;
    end else begin
      test_dout_out <= nxt_tdout;
    end
  end
  // analog route and amplifier power-down follow the selection register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      amux_sel_out <= `KSP_TST_INTG;
      amp_pwrdn_out <= 1'b0;
    end else begin
      amux_sel_out <= (test_sel_out[2]) ? test_sel_out : `KSP_TST_INTG; // see R6
      amp_pwrdn_out <= (test_sel_out == `KSP_TST_AAF); // see R14
    end
  end
  // ****************************************
  // integrate/hold sequencing
  // ****************************************
  ksp_int_e st_ff;
  ksp_int_e nxt_st;
  logic [15:0] lat_ff;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      KSP_HOLD: if (ih_s) nxt_st = KSP_ARM;
      KSP_ARM: begin
        if (!ih_s) begin
          nxt_st = KSP_HOLD;
        // sync and state entry are taken off, so the start stays inside the limit
        end else if (lat_ff >= 16'(`KSP_INT_LAT_CYC - `KSP_ENTRY_LAG)) begin
          nxt_st = KSP_INTEG; // see R12
        end
      end
      KSP_INTEG: if (!ih_s) nxt_st = KSP_REL;
      KSP_REL: begin
        if (ih_s) begin
          nxt_st = KSP_INTEG;
        end else if (lat_ff >= 16'(`KSP_HOLD_LAT_CYC - 1)) begin
          nxt_st = KSP_HOLD; // see R13
        end
      end
      default: nxt_st = KSP_HOLD;
    endcase
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= KSP_HOLD;
      lat_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      lat_ff <= (nxt_st != st_ff) ? 16'h0000 : lat_ff + 16'h0001;
    end
  end
  logic tog_arm_ff;
  // toggle status frozen at integration start, so a pulse cannot vouch for itself
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_arm_ff <= 1'b0;
    end else if (st_ff == KSP_ARM && nxt_st == KSP_INTEG) begin
      tog_arm_ff <= toggled_ff; // see R11
    end
  end
  // first completed integration is doubtful when the toggle was missed
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      first_result_ff <= 1'b1;
      result_valid_out <= 1'b0;
    end else if (st_ff == KSP_REL && nxt_st == KSP_HOLD) begin
      first_result_ff <= 1'b0;
      result_valid_out <= tog_arm_ff | ~first_result_ff; // see R11
    end
  end
  assign integrate_out = (st_ff == KSP_INTEG) || (st_ff == KSP_REL);
endmodule
`default_nettype wire

// >>> ksp_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ksp_checker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic int_hold_in,
  input wire logic cmp_in,
  input wire logic [5:0] ref_freq_out,
  input wire logic [5:0] knock_freq_out,
  input wire logic [5:0] balance_out,
  input wire logic [4:0] time_const_out,
  input wire logic [2:0] test_sel_out,
  input wire logic sensor_sel_out,
  input wire logic atten_ch_out,
  input wire logic [2:0] amux_sel_out,
  input wire logic amp_pwrdn_out,
  input wire logic test_dout_out,
  input wire logic integrate_out
);
  logic [11:0] hi_ff;
  logic [11:0] lo_ff;
  logic [4:0] sel_w;
  logic [27:0] regs_w;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // selection fields move together, so they count as one register
  assign sel_w = {test_sel_out, sensor_sel_out, atten_ch_out};
  assign regs_w = {ref_freq_out, knock_freq_out, balance_out, time_const_out, sel_w};
  // waiting time of the integrator behind the control input, both directions
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hi_ff <= 12'h000;
      lo_ff <= 12'h000;
    end else begin
      hi_ff <= (int_hold_in && !integrate_out) ? hi_ff + 12'h001 : 12'h000;
      lo_ff <= (!int_hold_in && integrate_out) ? lo_ff + 12'h001 : 12'h000;
    end
  end
  a_one_reg: assert property ($onehot0({$changed(ref_freq_out), $changed(knock_freq_out),
    $changed(balance_out), $changed(time_const_out), $changed(sel_w)}))
    else $error("more than one register written by one word");
  a_cs_gate: assert property ($changed(regs_w) |-> !$past(cs_n_in, 4))
    else $error("register written outside a selected frame");
  a_int_start: assert property (hi_ff <= 12'd1005 &&
    (!$rose(integrate_out) || hi_ff >= 12'd995))
    else $error("integration start latency out of bounds");
  a_hold_entry: assert property (lo_ff <= 12'd1005 &&
    (!$fell(integrate_out) || lo_ff >= 12'd995))
    else $error("hold entry latency out of bounds");
  a_dout_mosi: assert property ((test_sel_out == 3'h2 && $stable(mosi_in))[*5] |-> test_dout_out == !mosi_in)
    else $error("test output is not inverted serial data");
  a_dout_cmp: assert property ((test_sel_out == 3'h3 && $stable(cmp_in))[*4] |-> test_dout_out == cmp_in)
    else $error("test output is not the comparator");
  a_amux_route: assert property (($stable(test_sel_out) && test_sel_out inside {3'h0, 3'h7})[*3]
    |-> amux_sel_out == 3'h7) else $error("integrator not routed to the analog output");
  a_amp_pwrdn: assert property ($stable(test_sel_out)[*3] |-> amp_pwrdn_out == (test_sel_out == 3'h6))
    else $error("amplifier power-down does not follow the antialias code");
  c_word: cover property ($changed(regs_w));
  c_integ: cover property ($rose(integrate_out));
  c_aaf: cover property (amp_pwrdn_out);
endmodule
bind ksp_core ksp_checker chk_i (.*);
`default_nettype wire

// >>> ksp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ksp_host (
  input wire logic ref_clk_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask
  // fewer than eight bits gives an aborted word; hp sets the sck half period
  task automatic send(input logic [7:0] w, input int nb, input int hp);
    cs_n_out = 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      mosi_out = w[i];
      tick(hp); // data settles well before the rise
      sck_out = 1'b1;
      tick(hp);
      sck_out = 1'b0;
    end
    tick(hp);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // released line must not keep the last bit
    tick(hp); // deselected gap, so back to back words never merge
  endtask
endmodule
`default_nettype wire

// >>> knock_processor_serial_programming_tb.sv
`timescale 1ns/1ps
`default_nettype none
module knock_processor_serial_programming_tb;
  typedef struct packed {logic [7:0] w; logic [2:0] idx; logic [5:0] v;} ksp_row_s;
  logic ref_clk_in, rst_in, sck_in, cs_n_in, mosi_in, int_hold_in, cmp_in;
  logic [5:0] ref_freq_out, knock_freq_out, balance_out;
  logic [4:0] time_const_out;
  logic [2:0] test_sel_out, amux_sel_out;
  logic sensor_sel_out, atten_ch_out, amp_pwrdn_out, test_dout_out;
  logic integrate_out, data_valid_out, result_valid_out;
  logic [27:0] regs_w;
  logic [5:0] shd [5];
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  ksp_row_s rows [7] = '{'{8'h15, 3'h0, 6'h15}, '{8'h7f, 3'h1, 6'h3f}, '{8'haa, 3'h2, 6'h2a},
    '{8'hd6, 3'h3, 6'h16}, '{8'hc0, 3'h3, 6'h00}, '{8'hff, 3'h4, 6'h1f}, '{8'h3f, 3'h0, 6'h3f}};
  ksp_core DUT (.*);
  ksp_host host (.ref_clk_in, .sck_out(sck_in), .cs_n_out(cs_n_in), .mosi_out(mosi_in));
  assign regs_w = {ref_freq_out, knock_freq_out, balance_out, time_const_out, test_sel_out,
    sensor_sel_out, atten_ch_out};
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkregs();
    chk(regs_w, {shd[0], shd[1], shd[2], shd[3][4:0], shd[4][4:0]});
  endtask
  // whole word, then every register compared with the shadow copy
  task automatic wr(input logic [7:0] w, input int idx, input logic [5:0] v, input int hp);
    host.send(w, 8, hp);
    shd[idx] = v;
    chkregs();
  endtask
  // one integrate/hold cycle; the wait before it respects the quiet time after a frame
  task automatic integ(input logic exp);
    tick(400);
    int_hold_in = 1'b1;
    tick(1010);
    chk(integrate_out, 1'b1);
    int_hold_in = 1'b0;
    tick(1010);
    chk(integrate_out, 1'b0);
    chk(result_valid_out, exp);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    int_hold_in = 1'b0;
    cmp_in = 1'b0;
    foreach (shd[i]) shd[i] = 6'h00;
    tick(8);
    rst_in = 1'b0;
    tick(3);
    host.send(8'h15, 8, 4);
    chk(data_valid_out, 1'b0);
    wr(8'h0a, 0, 6'h0a, 4);
    chk(data_valid_out, 1'b1);
    integ(1'b0);
    integ(1'b1);
    foreach (rows[i]) wr(rows[i].w, rows[i].idx, rows[i].v, 4);
    // every test code, with the observable ones checked at the outputs
    for (int c = 0; c < 8; c++) begin
      wr(8'he0 | 8'(c << 2), 4, 6'(c << 2), 4);
      tick(6);
      chk(amp_pwrdn_out, c == 6);
      chk(amux_sel_out, (c >= 4) ? 3'(c) : 3'h7);
      // reference register holds all ones, so every bit index shows 1
      if (c == 1) chk(test_dout_out, 1'b1);
      if (c == 2) begin
        chk(test_dout_out, !mosi_in);
        host.send(8'h00, 0, 4); // empty frame flips the idle data line
        tick(6);
        chk(test_dout_out, !mosi_in);
      end
      if (c == 3) begin
        cmp_in = 1'b1;
        tick(6);
        chk(test_dout_out, 1'b1);
        cmp_in = 1'b0;
        tick(6);
        chk(test_dout_out, 1'b0);
      end
    end
    host.send(8'h55, 5, 4);
    tick(6);
    chkregs();
    wr(8'h4c, 1, 6'h0c, 4);
    wr(8'h8b, 2, 6'h0b, 8);
    // second reset, then the power-up toggle before the first word
    rst_in = 1'b1;
    tick(2);
    chk(amux_sel_out, 3'h7);
    foreach (shd[i]) shd[i] = 6'h00;
    rst_in = 1'b0;
    tick(3);
    chkregs();
    int_hold_in = 1'b1;
    tick(60);
    int_hold_in = 1'b0;
    tick(50);
    wr(8'h9c, 2, 6'h1c, 4);
    chk(data_valid_out, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
